// ---- core/restart_pkg.sv ----
package restart_pkg;

   // Register indices; byte address is four times the index
   localparam logic [3:0] IDX_STATUS = 4'h0;
   localparam logic [3:0] IDX_CFG0   = 4'h1;
   localparam logic [3:0] IDX_CFG1   = 4'h2;
   localparam logic [3:0] IDX_CFG2   = 4'h3;
   localparam logic [3:0] IDX_CFG3   = 4'h4;
   localparam logic [3:0] IDX_IRQ    = 4'h5;
   localparam logic [3:0] IDX_MUX    = 4'h6;
   localparam logic [3:0] IDX_SCAN   = 4'h7;
   localparam logic [3:0] IDX_TIMER  = 4'h8;
   localparam logic [3:0] IDX_OFFCAL = 4'h9;
   localparam logic [3:0] IDX_SCLCAL = 4'hA;
   localparam logic [3:0] IDX_RSVB   = 4'hB;
   localparam logic [3:0] IDX_RSVC   = 4'hC;
   localparam logic [3:0] IDX_LOCK   = 4'hD;
   localparam logic [3:0] IDX_SPARE  = 4'hE;
   localparam logic [3:0] IDX_CRC    = 4'hF;

   // Field positions (low bit of each field)
   localparam int F0_TOP   = 6;
   localparam int F0_CLK   = 4;
   localparam int F0_BURN  = 2;
   localparam int F0_MODE  = 0;
   localparam int F1_PRE   = 6;
   localparam int F2_BIAS  = 6;
   localparam int F3_SCL   = 1;
   localparam int F3_OFF   = 0;
   localparam int F5_IRQM  = 2;
   localparam int F5_STP   = 0;
   localparam int F7_DLY   = 21;
   localparam int ST_FLAG  = 0;

   // Masks and values after reset
   localparam logic [23:0] MASK_BYTE  = 24'h00_00FF;
   localparam logic [23:0] MASK_IRQ   = 24'h00_000F;
   localparam logic [23:0] MASK_SCAN  = 24'hE0_FFFF;
   localparam logic [23:0] MASK_WORD  = 24'hFF_FFFF;
   localparam logic [23:0] RST_IRQ    = 24'h00_0002;
   localparam logic [23:0] RST_LOCK   = 24'h00_00A5;
   localparam logic [23:0] RST_OTHER  = 24'h00_0000;
   localparam logic [7:0]  UNLOCK_KEY = 8'hA5;

   localparam logic [1:0] MODE_CONV = 2'b11;

   // Cycle counts at the master clock
   localparam logic [23:0] RESTART_CYC   = 24'h00_0002;
   localparam logic [23:0] RESTART_SLOW  = 24'h00_0004;
   localparam logic [23:0] SETUP_CYC     = 24'h00_0100;
   localparam logic [23:0] CONV_CYC      = 24'h00_0040;
   localparam logic [23:0] DLY_UNIT      = 24'h00_0004;

   // Background configuration checksum
   localparam logic [15:0] CRC_POLY = 16'h8005;
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [7:0]  CRC_BITS = 8'hC4;

   typedef enum logic [2:0] {
      ST_IDLE, ST_WAIT, ST_SETUP, ST_CONV, ST_DLY, ST_GAP
   } conv_state_t;

   typedef enum logic [1:0] {RK_NONE, RK_IMM, RK_DELAY, RK_STOP} restart_kind_t;

   typedef struct packed {
      logic reset;
      logic start;
      logic done;
   } conv_evt_t;

endpackage

// ---- core/conversion_auto_restart_ctrl.sv ----
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: No-effect bits never disturb running conversions
// RULE2: Immediate group: reset now, resume after two
// RULE3: Immediate group: mode, prescale, ratio, gain, chopping, etc
// RULE4: Correction enables, irq mode: only on change
// RULE5: Sequencer keeps position on immediate restart; a CFG0 write with mode 11 restarts from the first channel instead
// RULE6: Ignored-in-mode selection bits cause no restart
// RULE7: Correction values restart only when enabled
// RULE8: Mode restart only on 11, else stop
// RULE9: Delayed group: two cycles, then start-up timer
// RULE10: Delayed group: top bits, clock, burnout, bias, reserved
// RULE11: Unchanged clock/burnout/bias gives immediate restart
// RULE12: Sequencer keeps position on delayed restart
// RULE13: Delayed restart runs timer even in standby
// RULE14: Reset clears analog clock phase at once
// RULE15: Start pulse only after restart delay
// RULE16: Restart latency two to four cycles
// RULE17: Host avoids writes or enables start pulse
// RULE18: Single mode: timer/sequence writes no restart; a sequence write that enables a channel restarts at once
// RULE19: In cycle: sequence write restarts whole sequence
// RULE20: In gap: timer write restarts whole sequence
// RULE21: Writes rejected unless lock code matches; lock and status writes are still accepted while locked
// RULE22: Locked: background checksum, flag on change
// RULE23: Mixed write uses delayed restart behaviour
module conversion_auto_restart_ctrl
(
   // Clock and reset
   input  wire logic                  clk_i,
   input  wire logic                  rst_b_i,
   // APB slave
   input  wire logic                  psel_i,
   input  wire logic                  penable_i,
   input  wire logic                  pwrite_i,
   input  wire logic [7:0]            paddr_i,
   input  wire logic [31:0]           pwdata_i,
   output logic      [31:0]           prdata_o,
   output logic                       pready_o,
   output logic                       pslverr_o,
   // Converter side
   output restart_pkg::conv_evt_t     conv_evt_o,
   output logic                       divided_analog_clock_o,
   output logic      [3:0]            seq_position_o,
   output logic                       crc_mismatch_o
);
   import restart_pkg::*;

   logic [23:0]   reg_ff [0:15];
   conv_state_t   state_ff;
   logic [23:0]   cnt_ff;
   logic          delayed_ff;
   logic [3:0]    pos_ff;
   conv_evt_t     evt_ff;
   logic [3:0]    div_ff;
   logic          divided_analog_clock_ff;
   logic          pready_ff;
   logic          pslverr_ff;
   logic [31:0]   prdata_ff;
   logic [15:0]   crc_run_ff;
   logic [15:0]   crc_out_ff;
   logic [7:0]    crc_idx_ff;
   logic          crc_valid_ff;
   logic          crc_flag_ff;

   logic [3:0]    idx;
   logic          unlocked;
   logic          bad;
   logic          commit;
   logic [23:0]   nw;
   logic [23:0]   old;
   logic          seq_mode;
   logic          running;
   restart_kind_t rk;
   logic          seq_full;
   logic [31:0]   rd_data;
   logic [195:0]  crc_vec;
   logic [15:0]   crc_nxt;
   logic          crc_clear;

   function automatic logic [23:0] wmask(input logic [3:0] i);
      case (i)
         IDX_IRQ:                        wmask = MASK_IRQ;
         IDX_SCAN:                       wmask = MASK_SCAN;
         IDX_TIMER, IDX_OFFCAL, IDX_SCLCAL,
         IDX_RSVB, IDX_RSVC:             wmask = MASK_WORD;
         IDX_CFG0, IDX_CFG1, IDX_CFG2, IDX_CFG3,
         IDX_MUX, IDX_LOCK:              wmask = MASK_BYTE;
         default:                        wmask = RST_OTHER;
      endcase
   endfunction

   // Lowest set channel at or above from, else lowest set channel
   function automatic logic [3:0] pick_chan(input logic [15:0] m,
                                            input logic [4:0]  from);
      logic [3:0] r;
      r = 4'h0;
      for (int i = 15; i >= 0; i--) begin
         if (m[i]) r = 4'(i);
      end
      for (int i = 15; i >= 0; i--) begin
         if (m[i] && 5'(i) >= from) r = 4'(i);
      end
      return r;
   endfunction

   function automatic logic [23:0] dly_len(input logic [2:0] d);
      return (d == 3'h0) ? RST_OTHER : 24'(DLY_UNIT << d);
   endfunction

   assign idx      = paddr_i[5:2];
   assign unlocked = (reg_ff[IDX_LOCK][7:0] == UNLOCK_KEY);
   assign seq_mode = |reg_ff[IDX_SCAN][15:0];
   assign running  = (state_ff != ST_IDLE);
   assign nw       = pwdata_i[23:0] & wmask(idx);
   assign old      = reg_ff[idx];
   assign commit   = psel_i & penable_i & pready_ff & pwrite_i & ~pslverr_ff;

   // Status is write-one-to-clear and stays writable when locked
   always_comb begin
      bad = (paddr_i[1:0] != 2'b00) || (paddr_i[7:6] != 2'b00) ||
            (idx == IDX_SPARE);
      // RULE21: lock gates writes
      if (pwrite_i && (idx == IDX_CRC ||
          (!unlocked && idx != IDX_LOCK && idx != IDX_STATUS))) begin
         bad = 1'b1;
      end
   end

   always_comb begin
      case (idx)
         IDX_STATUS: rd_data = {22'h0, 3'(state_ff), pos_ff, seq_mode,
                                ~unlocked, crc_flag_ff};
         IDX_CRC:    rd_data = {16'h0, crc_out_ff};
         default:    rd_data = {8'h00, reg_ff[idx]};
      endcase
   end

   // Classify the effect of one committed write
   always_comb begin
      rk       = RK_NONE;
      seq_full = 1'b0;
      case (idx)
         IDX_CFG0: begin
            // RULE10: delayed group fields
            // RULE11: changed value adds start-up
            if (nw[F0_TOP+:2] != old[F0_TOP+:2] || nw[F0_CLK+:2] != old[F0_CLK+:2] ||
                nw[F0_BURN+:2] != old[F0_BURN+:2]) begin
               // RULE23: delayed wins
               rk = RK_DELAY;
            end else if (nw[F0_MODE+:2] == MODE_CONV) begin
               // RULE8: restart only on 11
               rk       = RK_IMM;
               seq_full = 1'b1;
            end else begin
               rk = RK_STOP;
            end
         end
         IDX_CFG2: begin
            if (nw[F2_BIAS+:2] != old[F2_BIAS+:2]) begin
               rk = RK_DELAY;
            end else if (running) begin
               rk = RK_IMM;
            end
         end
         // RULE3: immediate group member
         IDX_CFG1: rk = running ? RK_IMM : RK_NONE;
         IDX_CFG3: begin
            // RULE4: enables restart only on change
            // RULE1: format and link bits ignored
            if (running && nw[1:0] != old[1:0]) rk = RK_IMM;
         end
         IDX_IRQ: begin
            if (running && nw[F5_IRQM+:2] != old[F5_IRQM+:2]) rk = RK_IMM;
         end
         // RULE6: selection ignored in sequencer mode
         IDX_MUX: rk = (running && !seq_mode) ? RK_IMM : RK_NONE;
         IDX_SCAN: begin
            if (!seq_mode) begin
               // RULE18: enter sequencer at once
               if (|nw[15:0]) begin
                  rk       = RK_IMM;
                  seq_full = 1'b1;
               end
            end else if (running && state_ff != ST_GAP) begin
               // RULE19: whole sequence restarts
               rk       = RK_IMM;
               seq_full = 1'b1;
            end
         end
         IDX_TIMER: begin
            // RULE20: gap timer write restarts sequence
            if (seq_mode && state_ff == ST_GAP) begin
               rk       = RK_IMM;
               seq_full = 1'b1;
            end
         end
         // RULE7: correction value needs its enable
         IDX_OFFCAL: rk = (running && reg_ff[IDX_CFG3][F3_OFF]) ? RK_IMM : RK_NONE;
         IDX_SCLCAL: rk = (running && reg_ff[IDX_CFG3][F3_SCL]) ? RK_IMM : RK_NONE;
         IDX_RSVB, IDX_RSVC: rk = RK_DELAY;
         default: rk = RK_NONE;
      endcase
   end

   // APB answer: one wait state, write lands on the completing edge
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
      end else if (psel_i && penable_i && !pready_ff) begin
         pready_ff  <= 1'b1;
         pslverr_ff <= bad;
         prdata_ff  <= (pwrite_i || bad) ? 32'h0000_0000 : rd_data;
      end else begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         for (int i = 0; i < 16; i++) begin
            reg_ff[i] <= RST_OTHER;
         end
         reg_ff[IDX_IRQ]  <= RST_IRQ;
         reg_ff[IDX_LOCK] <= RST_LOCK;
      end else if (commit && idx != IDX_STATUS) begin
         reg_ff[idx] <= nw;
      end
   end

   // Analog clock divider, phase cleared by every restart
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         div_ff   <= 4'h0;
         divided_analog_clock_ff <= 1'b0;
      end else if (commit && rk != RK_NONE) begin
         // RULE14: phase reset, glitch accepted
         div_ff   <= 4'h0;
         divided_analog_clock_ff <= 1'b0;
      end else begin
         div_ff   <= div_ff + 4'h1;
         divided_analog_clock_ff <= div_ff[reg_ff[IDX_CFG1][F1_PRE+:2]];
      end
   end

   // Conversion sequencing and restart timing
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         state_ff   <= ST_IDLE;
         cnt_ff     <= RST_OTHER;
         delayed_ff <= 1'b0;
         pos_ff     <= 4'h0;
         evt_ff     <= '0;
      end else begin
         evt_ff <= '0;
         if (commit && rk == RK_STOP) begin
            state_ff     <= ST_IDLE;
            evt_ff.reset <= 1'b1;
         end else if (commit && rk != RK_NONE) begin
            // RULE2: reset now, resume later
            // RULE16: a write on a high clock phase waits two more
            state_ff     <= ST_WAIT;
            cnt_ff       <= (divided_analog_clock_ff ? RESTART_SLOW : RESTART_CYC) - 24'h00_0001;
            // RULE9: start-up timer pending
            // RULE13: also from standby
            delayed_ff   <= (rk == RK_DELAY);
            evt_ff.reset <= 1'b1;
            // RULE5: partial restart keeps position
            // RULE12: same for delayed group
            if (seq_full) begin
               pos_ff <= pick_chan((idx == IDX_SCAN) ? nw[15:0]
                                   : reg_ff[IDX_SCAN][15:0], 5'h00);
            end
         end else begin
            if (cnt_ff != RST_OTHER) cnt_ff <= cnt_ff - 24'h00_0001;
            case (state_ff)
               ST_WAIT: begin
                  if (cnt_ff == RST_OTHER) begin
                     if (delayed_ff) begin
                        state_ff <= ST_SETUP;
                        cnt_ff   <= SETUP_CYC - 24'h00_0001;
                     end else if (reg_ff[IDX_CFG0][F0_MODE+:2] == MODE_CONV) begin
                        state_ff     <= ST_CONV;
                        cnt_ff       <= CONV_CYC - 24'h00_0001;
                        // RULE15: pulse after restart delay
                        evt_ff.start <= reg_ff[IDX_IRQ][F5_STP];
                     end else begin
                        state_ff <= ST_IDLE;
                     end
                  end
               end
               ST_SETUP, ST_DLY, ST_GAP: begin
                  if (cnt_ff == RST_OTHER) begin
                     if (reg_ff[IDX_CFG0][F0_MODE+:2] == MODE_CONV) begin
                        state_ff     <= ST_CONV;
                        cnt_ff       <= CONV_CYC - 24'h00_0001;
                        evt_ff.start <= reg_ff[IDX_IRQ][F5_STP];
                     end else begin
                        state_ff <= ST_IDLE;
                     end
                  end
               end
               ST_CONV: begin
                  if (cnt_ff == RST_OTHER) begin
                     evt_ff.done <= 1'b1;
                     cnt_ff      <= CONV_CYC - 24'h00_0001;
                     if (seq_mode) begin
                        pos_ff <= pick_chan(reg_ff[IDX_SCAN][15:0], 5'(pos_ff) + 5'h01);
                        if (pick_chan(reg_ff[IDX_SCAN][15:0], 5'(pos_ff) + 5'h01)
                            <= pos_ff) begin
                           // Gap of timer value plus one cycle, so zero still leaves one idle cycle
                           state_ff <= ST_GAP;
                           cnt_ff   <= reg_ff[IDX_TIMER];
                        end else if (reg_ff[IDX_SCAN][F7_DLY+:3] != 3'h0) begin
                           state_ff <= ST_DLY;
                           cnt_ff   <= dly_len(reg_ff[IDX_SCAN][F7_DLY+:3])
                                       - 24'h00_0001;
                        end else begin
                           evt_ff.start <= reg_ff[IDX_IRQ][F5_STP];
                        end
                     end else begin
                        evt_ff.start <= reg_ff[IDX_IRQ][F5_STP];
                     end
                  end
               end
               default: state_ff <= ST_IDLE;
            endcase
         end
      end
   end

   // Every writable bit, walked one bit per cycle while locked
   assign crc_vec = {reg_ff[IDX_CFG0][7:0], reg_ff[IDX_CFG1][7:0],
                     reg_ff[IDX_CFG2][7:0], reg_ff[IDX_CFG3][7:0],
                     reg_ff[IDX_IRQ][3:0], reg_ff[IDX_MUX][7:0],
                     reg_ff[IDX_SCAN], reg_ff[IDX_TIMER], reg_ff[IDX_OFFCAL],
                     reg_ff[IDX_SCLCAL], reg_ff[IDX_RSVB], reg_ff[IDX_RSVC],
                     reg_ff[IDX_LOCK][7:0]};
   assign crc_nxt   = {crc_run_ff[14:0], 1'b0} ^
                      ((crc_run_ff[15] ^ crc_vec[crc_idx_ff]) ? CRC_POLY : 16'h0000);
   assign crc_clear = commit && idx == IDX_STATUS && pwdata_i[ST_FLAG];

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         crc_run_ff   <= CRC_INIT;
         crc_out_ff   <= 16'h0000;
         crc_idx_ff   <= 8'h00;
         crc_valid_ff <= 1'b0;
      end else if (unlocked) begin
         crc_run_ff   <= CRC_INIT;
         crc_idx_ff   <= 8'h00;
         crc_valid_ff <= 1'b0;
      end else if (crc_idx_ff == CRC_BITS - 8'h01) begin
         // RULE22: result of each full pass
         crc_run_ff   <= CRC_INIT;
         crc_out_ff   <= crc_nxt;
         crc_idx_ff   <= 8'h00;
         crc_valid_ff <= 1'b1;
      end else begin
         crc_run_ff <= crc_nxt;
         crc_idx_ff <= crc_idx_ff + 8'h01;
      end
   end

   // Set wins over a clear in the same cycle
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         crc_flag_ff <= 1'b0;
      end else if (!unlocked && crc_valid_ff && crc_idx_ff == CRC_BITS - 8'h01 &&
                   crc_nxt != crc_out_ff) begin
         // RULE22: flag on checksum change
         crc_flag_ff <= 1'b1;
      end else if (crc_clear) begin
         crc_flag_ff <= 1'b0;
      end
   end

   assign prdata_o               = prdata_ff;
   assign pready_o               = pready_ff;
   assign pslverr_o              = pslverr_ff;
   assign conv_evt_o             = evt_ff;
   assign divided_analog_clock_o = divided_analog_clock_ff;
   assign seq_position_o         = pos_ff;
   assign crc_mismatch_o         = crc_flag_ff;

endmodule // conversion_auto_restart_ctrl

// ---- sim/restart_checker.sv ----
`timescale 1ns/1ps
module restart_checker
   import restart_pkg::*;
(
   // Clock and reset
   input wire logic                   clk_i,
   input wire logic                   rst_b_i,
   // APB
   input wire logic                   psel_i,
   input wire logic                   penable_i,
   input wire logic                   pwrite_i,
   input wire logic [7:0]             paddr_i,
   input wire logic [31:0]            pwdata_i,
   input wire logic [31:0]            prdata_o,
   input wire logic                   pready_o,
   input wire logic                   pslverr_o,
   // Converter side
   input wire restart_pkg::conv_evt_t conv_evt_o,
   input wire logic                   divided_analog_clock_o,
   input wire logic [3:0]             seq_position_o,
   input wire logic                   crc_mismatch_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   logic [7:0] lock_ff;
   logic       stp_ff;
   logic       acc;
   logic       wr_ok;
   logic [3:0] idx;

   assign idx   = paddr_i[5:2];
   assign acc   = psel_i & penable_i & pready_o & pwrite_i;
   assign wr_ok = acc & ~pslverr_o;

   // Shadows follow accepted writes only
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         lock_ff <= RST_LOCK[7:0];
      end else if (wr_ok && idx == IDX_LOCK) begin
         lock_ff <= pwdata_i[7:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         stp_ff <= RST_IRQ[F5_STP];
      end else if (wr_ok && idx == IDX_IRQ) begin
         stp_ff <= pwdata_i[F5_STP];
      end
   end

   property p_lock_refuse;
      acc && lock_ff != UNLOCK_KEY && idx != IDX_LOCK && idx != IDX_STATUS |-> pslverr_o;
   endproperty
   a_lock_refuse: assert property (p_lock_refuse)
      else $error("write accepted while locked");

   property p_err_ready;
      pslverr_o |-> pready_o;
   endproperty
   a_err_ready: assert property (p_err_ready)
      else $error("error without ready");

   property p_quiet_lock;
      wr_ok && (idx == IDX_LOCK || idx == IDX_STATUS) |=> !conv_evt_o.reset;
   endproperty
   a_quiet_lock: assert property (p_quiet_lock)
      else $error("lock or status write restarted");

   property p_rsv_restart;
      wr_ok && (idx == IDX_RSVB || idx == IDX_RSVC) |=> conv_evt_o.reset;
   endproperty
   a_rsv_restart: assert property (p_rsv_restart)
      else $error("reserved write did not restart");

   property p_start_gap;
      conv_evt_o.reset |-> (!conv_evt_o.start) [*2];
   endproperty
   a_start_gap: assert property (p_start_gap)
      else $error("start within two cycles of restart");

   property p_stp_gate;
      conv_evt_o.start |-> stp_ff || $past(stp_ff);
   endproperty
   a_stp_gate: assert property (p_stp_gate)
      else $error("start pulse while disabled");

   property p_crc_locked;
      $rose(crc_mismatch_o) |-> lock_ff != UNLOCK_KEY || $past(lock_ff) != UNLOCK_KEY;
   endproperty
   a_crc_locked: assert property (p_crc_locked)
      else $error("checksum flag while unlocked");

   property p_pos_keep;
      wr_ok && idx == IDX_CFG1 |=> $stable(seq_position_o);
   endproperty
   a_pos_keep: assert property (p_pos_keep)
      else $error("sequence position moved on restart");

   sequence s_stop_wr;
      wr_ok && idx == IDX_CFG0 && pwdata_i[1:0] != MODE_CONV;
   endsequence
   property p_stop_quiet;
      s_stop_wr |=> (!conv_evt_o.start) [*8];
   endproperty
   a_stop_quiet: assert property (p_stop_quiet)
      else $error("start after stopping write");

   property p_phase_clr;
      conv_evt_o.reset |-> !divided_analog_clock_o;
   endproperty
   a_phase_clr: assert property (p_phase_clr)
      else $error("clock phase kept on restart");

   c_start: cover property (conv_evt_o.start);
   c_rsv: cover property (wr_ok && idx == IDX_RSVB);
   c_seq: cover property (seq_position_o != 4'h0);
endmodule // restart_checker

bind conversion_auto_restart_ctrl restart_checker u_chk (
   .clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
   .pready_o(pready_o), .pslverr_o(pslverr_o), .conv_evt_o(conv_evt_o),
   .divided_analog_clock_o(divided_analog_clock_o), .seq_position_o(seq_position_o),
   .crc_mismatch_o(crc_mismatch_o));

// ---- sim/host_apb_model.sv ----
`timescale 1ns/1ps
module host_apb_model (
   // Clock
   input  wire logic        clk_i,
   // APB master
   output logic             psel_o,
   output logic             penable_o,
   output logic             pwrite_o,
   output logic [7:0]       paddr_o,
   output logic [31:0]      pwdata_o,
   input  wire logic [31:0] prdata_i,
   input  wire logic        pready_i,
   input  wire logic        pslverr_i
);
   initial begin
      psel_o = 1'b0;
      penable_o = 1'b0;
      pwrite_o = 1'b0;
      paddr_o = 8'h00;
      pwdata_o = 32'h0000_0000;
   end

   // host leaves timing to start pulse
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e, output logic to);
      int n = 0;
      @(posedge clk_i);
      psel_o <= 1'b1;
      penable_o <= 1'b0;
      pwrite_o <= w;
      paddr_o <= a;
      pwdata_o <= d;
      @(posedge clk_i);
      penable_o <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready_i !== 1'b1 && n < 50);
      to = (pready_i !== 1'b1);
      q = prdata_i;
      e = pslverr_i;
      psel_o <= 1'b0;
      penable_o <= 1'b0;
      // Stale data is not left on the bus
      pwdata_o <= ~d;
   endtask
endmodule // host_apb_model

// ---- sim/conversion_auto_restart_ctrl_tb_top.sv ----
`timescale 1ns/1ps
module conversion_auto_restart_ctrl_tb_top;
   import restart_pkg::*;
   logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, aclk, crc_flag;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q, sum;
   logic [3:0]  pos;
   logic        e, got_start;
   conv_evt_t   evt;
   int          errors, n_tests, since, lat, i, n_rst;

   always #2.5 clk = ~clk;

   conversion_auto_restart_ctrl dut (
      .clk_i(clk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .conv_evt_o(evt),
      .divided_analog_clock_o(aclk), .seq_position_o(pos), .crc_mismatch_o(crc_flag));

   host_apb_model u_host (
      .clk_i(clk), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
      .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr));

   // Latency from restart pulse to first start pulse
   always @(posedge clk) begin
      if (evt.reset === 1'b1) begin
         n_rst <= n_rst + 1;
         got_start <= 1'b0;
         since <= 0;
      end else begin
         since <= since + 1;
         if (evt.start === 1'b1 && got_start !== 1'b1) begin
            got_start <= 1'b1;
            lat <= since;
         end
      end
   end

   task automatic wrap_up();
      $display("Comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
         errors++;
      end
   endtask

   function automatic logic [7:0] ad(input logic [3:0] x);
      return {2'b00, x, 2'b00};
   endfunction

   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
      logic to;
      u_host.xfer(w, a, d, q, e, to);
      if (to) begin
         $display("[FAIL] bus answer expected 1 seen 0");
         errors++;
         wrap_up();
      end
   endtask

   // Kind: 0 quiet, 1 immediate, 2 with start-up, 3 stop
   task automatic apply(input logic [3:0] x, input logic [31:0] d, input int kind);
      int mark = n_rst;
      acc(1'b1, ad(x), d);
      check("write error", 32'h0, e);
      for (int n = 0; n < ((kind == 1 || kind == 2) ? 300 : 12); n++) begin
         if (n_rst != mark && got_start === 1'b1)
            break;
         @(posedge clk);
      end
      check("restart pulse", (kind != 0), n_rst != mark);
      if (kind == 1)
         check("fast latency", 1, got_start === 1'b1 && lat >= 1 && lat <= 6);
      if (kind == 2)
         check("slow latency", 1, got_start === 1'b1 && lat >= 256 && lat <= 264);
      if (kind == 3)
         check("no start", 0, got_start);
   endtask

   initial begin
      clk = 1'b0;
      rst_b = 1'b0;
      errors = 0;
      n_tests = 0;
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      for (i = 0; i < 14; i++) begin
         acc(1'b0, ad(4'(i)), 32'h0);
         check("reset value", (i == 5) ? {8'h00, RST_IRQ} : (i == 13) ? {8'h00, RST_LOCK} : 32'h0, q);
      end
      acc(1'b0, ad(IDX_SPARE), 32'h0);
      check("spare error", 32'h1, e);
      acc(1'b0, 8'h05, 32'h0);
      check("unaligned error", 32'h1, e);
      apply(IDX_IRQ, 32'h0000_0003, 0);
      apply(IDX_CFG0, 32'h0000_0003, 1);
      apply(IDX_CFG3, 32'h0000_00C0, 0);
      apply(IDX_LOCK, 32'h0000_00A5, 0);
      apply(IDX_CFG1, 32'h0000_0004, 1);
      apply(IDX_CFG2, 32'h0000_0008, 1);
      apply(IDX_CFG2, 32'h0000_000C, 1);
      apply(IDX_CFG3, 32'h0000_00C1, 1);
      apply(IDX_CFG3, 32'h0000_00C1, 0);
      apply(IDX_OFFCAL, 32'h0012_3456, 1);
      apply(IDX_SCLCAL, 32'h0000_0001, 0);
      apply(IDX_IRQ, 32'h0000_000B, 1);
      apply(IDX_IRQ, 32'h0000_000B, 0);
      apply(IDX_SCAN, 32'h0020_0000, 0);
      apply(IDX_TIMER, 32'h0000_0010, 0);
      apply(IDX_MUX, 32'h0000_0001, 1);
      apply(IDX_CFG0, 32'h0000_0013, 2);
      apply(IDX_CFG0, 32'h0000_0013, 1);
      apply(IDX_CFG2, 32'h0000_004C, 2);
      apply(IDX_RSVB, 32'h0000_0000, 2);
      apply(IDX_RSVC, 32'h0000_0000, 2);
      apply(IDX_CFG0, 32'h0000_00D3, 2);
      apply(IDX_SCAN, 32'h0000_0003, 1);
      acc(1'b0, ad(IDX_STATUS), 32'h0);
      check("sequencer mode", 32'h1, q[2]);
      apply(IDX_MUX, 32'h0000_0022, 0);
      apply(IDX_TIMER, 32'h0000_0020, 0);
      apply(IDX_SCAN, 32'h0000_0003, 1);
      apply(IDX_CFG1, 32'h0000_0008, 1);
      apply(IDX_CFG2, 32'h0000_008C, 2);
      apply(IDX_CFG0, 32'h0000_00D2, 3);
      apply(IDX_CFG0, 32'h0000_00F2, 3);
      acc(1'b0, ad(IDX_STATUS), 32'h0);
      check("start-up timer", 32'h2, q[9:7]);
      apply(IDX_LOCK, 32'h0000_0000, 0);
      acc(1'b1, ad(IDX_CFG1), 32'h0000_00FF);
      check("locked write error", 32'h1, e);
      acc(1'b0, ad(IDX_CFG1), 32'h0);
      check("config kept", 32'h0000_0008, q);
      acc(1'b0, ad(IDX_STATUS), 32'h0);
      check("locked flag", 32'h1, q[1]);
      repeat (400) @(posedge clk);
      acc(1'b0, ad(IDX_CRC), 32'h0);
      sum = q;
      repeat (400) @(posedge clk);
      acc(1'b0, ad(IDX_CRC), 32'h0);
      check("checksum steady", sum, q);
      check("checksum flag", 32'h0, crc_flag);
      acc(1'b1, ad(IDX_CRC), 32'h0000_1234);
      check("checksum write error", 32'h1, e);
      acc(1'b1, ad(IDX_LOCK), 32'h0000_00A5);
      check("unlock error", 32'h0, e);
      acc(1'b1, ad(IDX_CFG1), 32'h0000_0004);
      check("unlocked write error", 32'h0, e);
      wrap_up();
   end
endmodule // conversion_auto_restart_ctrl_tb_top
